// [rtl/fcb_coef_bank.sv]
`timescale 1ns/1ps
module fcb_coef_bank (
  input  wire logic                         CLOCK,
  input  wire logic                         RST_N,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [fcb_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [fcb_pkg::DATA_W-1:0]   PWDATA,
  input  wire logic [fcb_pkg::STRB_W-1:0]   PSTRB,
  output logic      [fcb_pkg::DATA_W-1:0]   PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  input  wire fcb_pkg::fcb_sample_t         SAMPLE_IN,
  output fcb_pkg::fcb_result_t              RESULT_OUT
);
  import fcb_pkg::*;

  // Coefficient storage, reserved bits included
  logic [TAP_N-1:0][REG_W-1:0]    coef_q;
  // Coefficients sign-extended to the center width for the filter
  logic [TAP_N-1:0][CENTER_W-1:0] coef_x;
  // Per-tap write masks after byte strobes
  logic [TAP_N-1:0][REG_W-1:0]    wmask;

  logic                   dual_q;      // Dual-channel mode enable
  logic [CNT_W-1:0]       cnt_q;       // Filter outputs produced
  logic [DATA_W-1:0]      prdata_q;    // Read data captured at setup
  logic                   err_q;       // Unmapped access seen at setup
  logic [DATA_W-1:0]      rd_data;     // Read mux
  logic [REG_W-1:0]       lane_mask;   // Strobes spread over bits
  logic [TAP_N-1:0]       tap_hit;     // Address selects a tap
  logic                   ctrl_hit;    // Address selects control
  logic                   stat_hit;    // Address selects status
  logic                   aligned;     // Word-aligned address
  logic                   mapped;      // Any register selected
  logic                   setup;       // APB setup phase
  logic                   wr_en;       // APB write taking effect
  logic [IDX_W-1:0]       idx;         // Word index of the address
  fcb_result_t            fir_out;     // Filter output

  // Address decode
  assign idx     = PADDR[ADDR_W-1:2];
  assign aligned = (PADDR[1:0] == 2'h0);

  // One comparator per tap register
  for (genvar k = 0; k < TAP_N; k++) begin : g_hit
    assign tap_hit[k] = aligned && (idx == TAP_IDX[k]);
  end

  assign ctrl_hit = aligned && (idx == CTRL_IDX);
  assign stat_hit = aligned && (idx == STAT_IDX);
  assign mapped   = (|tap_hit) || ctrl_hit || stat_hit;

  // Phase qualifiers; a flagged access never writes
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && !err_q;

  // Zero wait states: every access completes in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && err_q;
  assign PRDATA  = prdata_q;

  // Byte strobes cover the three low lanes that registers use
  always_comb begin
    lane_mask = '0;
    for (int b = 0; b < REG_W / 8; b++) begin
      lane_mask[b*8 +: 8] = {8{PSTRB[b]}};
    end
  end

  // Tap registers; bits outside the mask never leave zero
  for (genvar k = 0; k < TAP_N; k++) begin : g_tap
    assign wmask[k] = TAP_MASK[k] & lane_mask;

    always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
        coef_q[k] <= COEF_RST;
      end else if (wr_en && tap_hit[k]) begin
        coef_q[k] <= (coef_q[k] & ~wmask[k]) | (PWDATA[REG_W-1:0] & wmask[k]);
      end
    end

    // Center uses its full field, outer taps sign-extend the low twelve bits
    if (k == CENTER_TAP) begin : g_ctr
      assign coef_x[k] = coef_q[k][CENTER_W-1:0];
    end else begin : g_outer
      assign coef_x[k] = CENTER_W'($signed(coef_q[k][COEF_W-1:0]));
    end
  end

  // Mode control; software selects dual-channel operation
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      dual_q <= 1'b0;
    end else if (wr_en && ctrl_hit && PSTRB[0]) begin
      dual_q <= PWDATA[CTRL_DUAL_BIT];
    end
  end

  // Output counter for status; wraps silently
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cnt_q <= '0;
    end else if (fir_out.vld) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Read mux; reserved bits read back as stored, unused bits read zero
  always_comb begin
    rd_data = RD_RST;
    for (int k = 0; k < TAP_N; k++) begin
      if (tap_hit[k]) begin
        rd_data = DATA_W'(coef_q[k]);
      end
    end
    // Readback of the ninth tap loses its sign bit
    if (tap_hit[LAST_TAP]) begin
      rd_data[TAP9_MSB] = 1'b0;
    end
    if (ctrl_hit) begin
      rd_data[CTRL_DUAL_BIT] = dual_q;
    end
    if (stat_hit) begin
      rd_data[STAT_RUN_BIT]             = dual_q;
      rd_data[STAT_CNT_LSB +: CNT_W]    = cnt_q;
    end
  end

  // Read data and error are frozen at setup so PRDATA comes from a flop;
  // writes only happen in access phases, so the capture cannot be stale
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      prdata_q <= RD_RST;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_data;
      err_q    <= !mapped;
    end
  end

  // Channel B filter; gated by dual-channel mode
  fcb_fir #(
    .TAPS (TAP_N),
    .CW   (CENTER_W)
  ) u_fir (
    .clk        (CLOCK),
    .rst_n      (RST_N),
    .enable     (dual_q),
    .coef       (coef_x),
    .sample_in  (SAMPLE_IN),
    .result_out (fir_out)
  );

  assign RESULT_OUT = fir_out;

  // Setup phase addressed to one register
  sequence s_setup(logic [IDX_W-1:0] at);
    PSEL && !PENABLE && PADDR == {at, 2'h0};
  endsequence

  // Full-word write taking effect at one register
  sequence s_write(logic [IDX_W-1:0] at);
    PSEL && PENABLE && PWRITE && PSTRB == {STRB_W{1'b1}} && PADDR == {at, 2'h0};
  endsequence

  // Setup to an unmapped address followed by its access phase
  sequence s_bad_access;
    PSEL && !PENABLE && !mapped ##1 PSEL && PENABLE;
  endsequence

  property p_tap_field;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(TAP_IDX[0]) |=> coef_q[0] == (TAP_MASK[0] & $past(PWDATA[REG_W-1:0]));
  endproperty
  a_tap_field: assert property (p_tap_field)
    else $error("Outer tap did not keep exactly sixteen bits");

  property p_center_field;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(TAP_IDX[CENTER_TAP]) |=> coef_q[CENTER_TAP] == $past(PWDATA[REG_W-1:0]);
  endproperty
  a_center_field: assert property (p_center_field)
    else $error("Center tap did not keep twenty-four bits");

  property p_dual_gate;
    @(posedge CLOCK) disable iff (!RST_N)
      !dual_q |=> !RESULT_OUT.vld;
  endproperty
  a_dual_gate: assert property (p_dual_gate)
    else $error("Filter output outside dual-channel mode");

  property p_even_map;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(TAP_IDX[1]) |=> PRDATA == DATA_W'($past(coef_q[1]));
  endproperty
  a_even_map: assert property (p_even_map)
    else $error("Second tap not read at its even address");

  property p_odd_map;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(TAP_IDX[5]) |=> PRDATA == DATA_W'($past(coef_q[5]));
  endproperty
  a_odd_map: assert property (p_odd_map)
    else $error("Sixth tap not read at its odd address");

  property p_reset_clear;
    @(posedge CLOCK)
      !RST_N |=> coef_q == '0 && !dual_q && PRDATA == RD_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Coefficients not cleared by reset");

  property p_tap9_msb;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(TAP_IDX[LAST_TAP]) |=> !PRDATA[TAP9_MSB]
        && PRDATA[TAP9_MSB-1:0] == $past(coef_q[LAST_TAP][TAP9_MSB-1:0]);
  endproperty
  a_tap9_msb: assert property (p_tap9_msb)
    else $error("Ninth tap readback wrong");

  property p_unmapped;
    @(posedge CLOCK) disable iff (!RST_N)
      s_bad_access |-> PSLVERR && PREADY;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access not flagged");

  // Write to the control word with its low lane enabled
  sequence s_ctrl_write;
    PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == {CTRL_IDX, 2'h0};
  endsequence

  // Center tap written through its upper lane only
  sequence s_lane2_write;
    PSEL && PENABLE && PWRITE && PSTRB == 4'h4 && PADDR == {TAP_IDX[CENTER_TAP], 2'h0};
  endsequence

  property p_outer_upper;
    @(posedge CLOCK) disable iff (!RST_N)
      coef_q[0][REG_W-1:16] == '0 && coef_q[LAST_TAP][REG_W-1:16] == '0;
  endproperty
  a_outer_upper: assert property (p_outer_upper)
    else $error("Outer tap holds bits above its sixteen");

  property p_center_lane;
    @(posedge CLOCK) disable iff (!RST_N)
      s_lane2_write |=> coef_q[CENTER_TAP][15:0] == $past(coef_q[CENTER_TAP][15:0])
        && coef_q[CENTER_TAP][REG_W-1:16] == $past(PWDATA[REG_W-1:16]);
  endproperty
  a_center_lane: assert property (p_center_lane)
    else $error("Center tap lane write wrong");

  property p_dual_write;
    @(posedge CLOCK) disable iff (!RST_N)
      s_ctrl_write |=> dual_q == $past(PWDATA[CTRL_DUAL_BIT]);
  endproperty
  a_dual_write: assert property (p_dual_write)
    else $error("Dual mode bit not written");

  property p_dual_pass;
    @(posedge CLOCK) disable iff (!RST_N)
      dual_q && SAMPLE_IN.vld |=> RESULT_OUT.vld;
  endproperty
  a_dual_pass: assert property (p_dual_pass)
    else $error("Sample dropped in dual-channel mode");

  property p_tap4_map;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(TAP_IDX[3]) |=> PRDATA == DATA_W'($past(coef_q[3]));
  endproperty
  a_tap4_map: assert property (p_tap4_map)
    else $error("Fourth tap not read at its even address");

  property p_tap8_map;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(TAP_IDX[7]) |=> PRDATA == DATA_W'($past(coef_q[7]));
  endproperty
  a_tap8_map: assert property (p_tap8_map)
    else $error("Eighth tap not read at its odd address");

  property p_tap9_store;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(TAP_IDX[LAST_TAP]) |=> coef_q[LAST_TAP] == (TAP_MASK[LAST_TAP] & $past(PWDATA[REG_W-1:0]));
  endproperty
  a_tap9_store: assert property (p_tap9_store)
    else $error("Ninth tap not stored in full");

  property p_coef_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      !(PSEL && PENABLE && PWRITE) |=> $stable(coef_q);
  endproperty
  a_coef_hold: assert property (p_coef_hold)
    else $error("Coefficient changed without a write");

  property p_bad_no_write;
    @(posedge CLOCK) disable iff (!RST_N)
      PSLVERR |=> $stable(coef_q) && $stable(dual_q);
  endproperty
  a_bad_no_write: assert property (p_bad_no_write)
    else $error("Refused access changed a register");

  property p_unmapped_read;
    @(posedge CLOCK) disable iff (!RST_N)
      PSEL && !PENABLE && !mapped |=> PRDATA == RD_RST;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read did not return zero");

  property p_err_window;
    @(posedge CLOCK) disable iff (!RST_N)
      !(PSEL && PENABLE) |-> !PSLVERR;
  endproperty
  a_err_window: assert property (p_err_window)
    else $error("Error flag outside an access phase");

  property p_ready;
    @(posedge CLOCK) disable iff (!RST_N)
      PSEL && PENABLE |-> PREADY;
  endproperty
  a_ready: assert property (p_ready)
    else $error("Access phase not completed at once");

  property p_ctrl_read;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(CTRL_IDX) |=> PRDATA == DATA_W'($past(dual_q));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("Control readback wrong");

  property p_stat_read;
    @(posedge CLOCK) disable iff (!RST_N)
      s_setup(STAT_IDX) |=> PRDATA[STAT_CNT_LSB +: CNT_W] == $past(cnt_q)
        && PRDATA[STAT_RUN_BIT] == $past(dual_q);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("Status readback wrong");

  property p_count_step;
    @(posedge CLOCK) disable iff (!RST_N)
      fir_out.vld |=> cnt_q == CNT_W'($past(cnt_q) + CNT_W'(1));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Output counter did not advance");

endmodule

// [rtl/fcb_pkg.sv]
package fcb_pkg;

  // Filter shape
  localparam int TAP_N      = 9;          // Taps per channel
  localparam int CENTER_TAP = 4;          // Fifth tap, zero based
  localparam int LAST_TAP   = TAP_N - 1;  // Ninth tap, zero based
  localparam int SAMPLE_W   = 12;         // Converter sample width
  localparam int COEF_W     = 12;         // Outer tap coefficient field
  localparam int CENTER_W   = 18;         // Center tap coefficient field
  localparam int REG_W      = 24;         // Widest coefficient register
  localparam int RESULT_W   = 34;         // Nine products summed without overflow

  // APB geometry
  localparam int ADDR_W = 16;             // Byte address width
  localparam int DATA_W = 32;             // Bus data width
  localparam int IDX_W  = ADDR_W - 2;     // Register index width
  localparam int STRB_W = DATA_W / 8;     // Byte strobes

  // Register index of each tap; byte address is four times this
  localparam logic [IDX_W-1:0] TAP_IDX [TAP_N] = '{
    14'h0448, 14'h044a, 14'h044c, 14'h044e, 14'h0450,
    14'h0453, 14'h0455, 14'h0457, 14'h0459
  };

  // Storage width of each tap register, reserved bits included
  localparam logic [REG_W-1:0] TAP_MASK [TAP_N] = '{
    24'h00ffff, 24'h00ffff, 24'h00ffff, 24'h00ffff, 24'hffffff,
    24'h00ffff, 24'h00ffff, 24'h00ffff, 24'h00ffff
  };

  // Mode control and status registers
  localparam logic [IDX_W-1:0] CTRL_IDX = 14'h0460;
  localparam logic [IDX_W-1:0] STAT_IDX = 14'h0461;
  localparam int CTRL_DUAL_BIT = 0;       // Dual-channel mode enable
  localparam int STAT_RUN_BIT  = 0;       // Filter running
  localparam int STAT_CNT_LSB  = 16;      // Output counter field
  localparam int CNT_W         = 16;      // Output counter width
  localparam int TAP9_MSB      = COEF_W - 1;  // Bit that reads back as zero

  // Reset values
  localparam logic [REG_W-1:0]  COEF_RST = 24'h000000;
  localparam logic [DATA_W-1:0] RD_RST   = 32'h00000000;

  // Sample stream into the filter
  typedef struct packed {
    logic                       vld;
    logic signed [SAMPLE_W-1:0] data;
  } fcb_sample_t;

  // Filter output stream
  typedef struct packed {
    logic                       vld;
    logic signed [RESULT_W-1:0] data;
  } fcb_result_t;

endpackage

// [rtl/fcb_fir.sv]
`timescale 1ns/1ps
module fcb_fir #(
  parameter int TAPS = fcb_pkg::TAP_N,
  parameter int CW   = fcb_pkg::CENTER_W
)(
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            enable,
  input  wire logic [TAPS-1:0][CW-1:0]         coef,
  input  wire fcb_pkg::fcb_sample_t            sample_in,
  output fcb_pkg::fcb_result_t                 result_out
);
  import fcb_pkg::*;

  logic signed [SAMPLE_W-1:0] line_q [TAPS-1];  // Older samples, newest first
  logic signed [SAMPLE_W-1:0] win    [TAPS];    // Current nine-sample window
  logic signed [RESULT_W-1:0] acc;              // Weighted sum
  fcb_result_t                res_q;            // Registered output
  logic                       only_ctr;         // Helper for checking

  // Window: incoming sample plus the stored history
  always_comb begin
    win[0] = sample_in.data;
    for (int k = 1; k < TAPS; k++) begin
      win[k] = line_q[k-1];
    end
  end

  // Widen before multiplying so no product is cut short
  always_comb begin
    acc = '0;
    for (int k = 0; k < TAPS; k++) begin
      acc = acc + RESULT_W'(win[k]) * RESULT_W'($signed(coef[k]));
    end
  end

  // History only moves while the filter is enabled; stale samples
  // remain after a mode change until eight new ones arrive
  for (genvar k = 0; k < TAPS - 1; k++) begin : g_line
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        line_q[k] <= '0;
      end else if (enable && sample_in.vld) begin
        line_q[k] <= win[k];
      end
    end
  end

  // Output register, one cycle after the sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_q <= '0;
    end else begin
      res_q.vld <= enable && sample_in.vld;
      if (enable && sample_in.vld) begin
        res_q.data <= acc;
      end
    end
  end

  assign result_out = res_q;

  // True when only the center tap is one and all others are zero
  always_comb begin
    only_ctr = (coef[CENTER_TAP] == CW'(1));
    for (int k = 0; k < TAPS; k++) begin
      if (k != CENTER_TAP && coef[k] != '0) begin
        only_ctr = 1'b0;
      end
    end
  end

  property p_center_weight;
    @(posedge clk) disable iff (!rst_n)
      enable && sample_in.vld && only_ctr |=> result_out.data == RESULT_W'($past(win[CENTER_TAP]));
  endproperty
  a_center_weight: assert property (p_center_weight)
    else $error("Center tap does not weight the middle sample");

endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import fcb_pkg::*;

  logic                CLOCK;       // Bench clock, 200 MHz
  logic                RST_N;       // Synchronous reset, low active
  logic                PSEL;        // APB select
  logic                PENABLE;     // APB access phase
  logic                PWRITE;      // APB direction
  logic [ADDR_W-1:0]   PADDR;       // APB byte address
  logic [DATA_W-1:0]   PWDATA;      // APB write data
  logic [STRB_W-1:0]   PSTRB;       // APB byte strobes
  logic [DATA_W-1:0]   PRDATA;      // APB read data
  logic                PREADY;      // APB ready
  logic                PSLVERR;     // APB error
  fcb_sample_t         SAMPLE_IN;   // Sample stream in
  fcb_result_t         RESULT_OUT;  // Filter output
  logic [DATA_W:0]     apb_q[$];    // Expected {error, read data}
  logic [RESULT_W-1:0] res_q[$];    // Expected filter outputs
  logic [REG_W-1:0]    regv[TAP_N]; // Bits each tap register holds
  int                  coef[TAP_N]; // Coefficient as the filter uses it
  int                  hist[TAP_N]; // Accepted samples, newest first
  int                  fail_count;  // Mismatches
  int                  checked;     // Comparisons made
  int                  n_out;       // Outputs expected so far
  logic                dual;        // Dual-channel mode as last written

  fcb_coef_bank dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
                     .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
                     .PSLVERR(PSLVERR), .SAMPLE_IN(SAMPLE_IN), .RESULT_OUT(RESULT_OUT));

  // Clock toggles every half period
  initial CLOCK = 1'b0;
  always #2.5 CLOCK = ~CLOCK;

  // Compare, count, report at once
  task automatic chk(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
                     input logic [STRB_W-1:0] s, input logic [DATA_W:0] e);
    int n;
    apb_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge CLOCK);
    // Slave never answered: give up on the run
    if (n >= 20) begin
      chk('1, '0, "apb timeout");
      wrap_up();
    end
  endtask

  // Write a tap and track which bits it now holds; lane 3 is beyond every tap
  task automatic set_tap(input int k, input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s);
    for (int b = 0; b < 3; b++)
      if (s[b]) regv[k][8*b +: 8] = d[8*b +: 8];
    regv[k] = regv[k] & TAP_MASK[k];
    coef[k] = (k == CENTER_TAP) ? int'($signed(regv[k][CENTER_W-1:0])) : int'($signed(regv[k][COEF_W-1:0]));
    apb({TAP_IDX[k], 2'b00}, 1'b1, d, s, '0);
  endtask

  // Read all taps back in order
  task automatic rd_taps();
    logic [DATA_W-1:0] e;
    for (int k = 0; k < TAP_N; k++) begin
      e = DATA_W'(regv[k]);
      if (k == LAST_TAP) e[TAP9_MSB] = 1'b0;
      apb({TAP_IDX[k], 2'b00}, 1'b0, '0, '0, {1'b0, e});
    end
  endtask

  // Dual-channel mode on or off through the control word
  task automatic set_dual(input logic v);
    dual = v;
    apb({CTRL_IDX, 2'b00}, 1'b1, {31'h0, v}, 4'h1, '0);
  endtask

  // Back-to-back samples, extreme negative first; model follows accepted ones only
  task automatic stream(input int n);
    longint            acc;
    logic [SAMPLE_W-1:0] x;
    for (int i = 0; i < n; i++) begin
      x = (i == 0) ? 12'h800 : SAMPLE_W'($urandom);
      SAMPLE_IN.vld <= 1'b1;
      SAMPLE_IN.data <= x;
      if (dual) begin
        for (int k = LAST_TAP; k > 0; k--) hist[k] = hist[k-1];
        hist[0] = int'($signed(x));
        acc = 0;
        for (int k = 0; k < TAP_N; k++) acc += longint'(coef[k]) * hist[k];
        res_q.push_back(acc[RESULT_W-1:0]);
        n_out++;
      end
      @(posedge CLOCK);
    end
    SAMPLE_IN.vld <= 1'b0;
  endtask

  // Watch completed transfers and outputs; each takes the oldest note
  always @(posedge CLOCK) begin
    logic [DATA_W:0] e;
    if (RST_N && PSEL && PENABLE && PREADY === 1'b1) begin
      if (apb_q.size() == 0) chk('1, '0, "stray transfer");
      else begin
        e = apb_q.pop_front();
        chk(RESULT_W'(PSLVERR), RESULT_W'(e[DATA_W]), "error flag");
        if (!PWRITE) chk(RESULT_W'(PRDATA), RESULT_W'(e[DATA_W-1:0]), "read data");
      end
    end
    if (RST_N && RESULT_OUT.vld === 1'b1) begin
      if (res_q.size() == 0) chk('1, '0, "stray output");
      else chk(RESULT_OUT.data, res_q.pop_front(), "filter output");
    end
  end

  // Main sequence
  initial begin
    int seed;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    SAMPLE_IN = '0;
    RST_N = 1'b0;
    dual = 1'b0;
    fail_count = 0;
    checked = 0;
    n_out = 0;
    foreach (regv[k]) begin
      regv[k] = '0;
      coef[k] = 0;
      hist[k] = 0;
    end
    seed = $urandom(44);
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    // Everything reads zero out of reset
    rd_taps();
    apb({CTRL_IDX, 2'b00}, 1'b0, '0, '0, '0);
    $display("test reset values done");
    // Random words to every tap, reserved bits included, then byte lanes alone
    for (int k = 0; k < TAP_N; k++) set_tap(k, $urandom, 4'hf);
    rd_taps();
    set_tap(CENTER_TAP, $urandom, 4'h4);
    set_tap(0, 32'hffffffff, 4'h1);
    rd_taps();
    $display("test readback done");
    // Holes in the map and misaligned words answer with an error
    apb({14'h0449, 2'b00}, 1'b1, '1, 4'hf, {1'b1, 32'h0});
    apb({14'h0452, 2'b00}, 1'b0, '0, '0, {1'b1, 32'h0});
    apb({TAP_IDX[0], 2'b10}, 1'b1, '0, 4'hf, {1'b1, 32'h0});
    rd_taps();
    $display("test refusal done");
    // Samples dropped in single mode; history survives a mode toggle
    stream(5);
    set_dual(1'b1);
    stream(24);
    set_dual(1'b0);
    stream(4);
    set_dual(1'b1);
    stream(12);
    // Only the center tap at one: each output is the middle sample
    for (int k = 0; k < TAP_N; k++) set_tap(k, (k == CENTER_TAP) ? 32'h1 : 32'h0, 4'hf);
    stream(10);
    apb({CTRL_IDX, 2'b00}, 1'b0, '0, '0, {1'b0, 31'h0, dual});
    // Status ignores writes, echoes mode and output count
    apb({STAT_IDX, 2'b00}, 1'b1, '1, 4'hf, '0);
    apb({STAT_IDX, 2'b00}, 1'b0, '0, '0, {1'b0, n_out[15:0], 15'h0, dual});
    $display("test filter done");
    // Reset in mid-run clears taps and mode again
    RST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    foreach (regv[k]) begin
      regv[k] = '0;
      coef[k] = 0;
      hist[k] = 0;
    end
    dual = 1'b0;
    @(posedge CLOCK);
    rd_taps();
    stream(3);
    repeat (4) @(posedge CLOCK);
    if (apb_q.size() != 0 || res_q.size() != 0) chk('1, '0, "missing answers");
    $display("test second reset done");
    wrap_up();
  end
endmodule
